// *** inc/cbpt_defs.svh ***
// Constants for the cardbus/PCI target decoder.
`ifndef CBPT_DEFS_SVH
`define CBPT_DEFS_SVH
// ----------------------------------------------------------------------
// Bus commands
// ----------------------------------------------------------------------
`define CBPT_CMD_IO_RD    4'h2
`define CBPT_CMD_IO_WR    4'h3
`define CBPT_CMD_MEM_RD   4'h6
`define CBPT_CMD_MEM_WR   4'h7
`define CBPT_CMD_CFG_RD   4'ha
`define CBPT_CMD_CFG_WR   4'hb
// ----------------------------------------------------------------------
// Configuration space layout
// ----------------------------------------------------------------------
`define CBPT_CIS_PTR_IDX  6'h0a
`define CBPT_CIS_PTR_VAL  32'h0000_0048
`define CBPT_CFG_IMPL_TOP 6'h13
// Field positions of the byte-lane select.
`define CBPT_LANE_HI      4
`define CBPT_LANE_LO      3
// Decode latency from the first FRAME# low sample to DEVSEL#, in clocks.
`define CBPT_DEVSEL_DLY   2'h2
`endif

// *** inc/cbpt_pkg.sv ***
// Types shared by the cardbus/PCI target decoder.
package cbpt_pkg;
  // --------------------------------------------------------------------
  // Regions a claimed access can land in
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    CBPT_RG_CFG, CBPT_RG_UART_IO, CBPT_RG_UART_MEM,
    CBPT_RG_LCL_IO, CBPT_RG_LCL_MEM, CBPT_RG_STAT
  } cbpt_region_type;

  // Internal register access request.
  typedef struct packed {
    logic            rd;
    logic            wr;
    cbpt_region_type region;
    logic [7:0]      addr;
    logic [3:0]      be;
    logic [31:0]     wdata;
  } cbpt_req_type;
endpackage : cbpt_pkg

// *** src/cbpt_target.sv ***
// Cardbus/PCI target decoder routing bus cycles to internal regions.
// Function
// [R1] Cardbus mode default; EEPROM may select PCI.
// [R2] CARD_INFORMATION_STRUCTURE pointer lives at config dword 0A.
// [R3] Cardbus claims type 0 function 0 configs.
// [R4] PCI mode also requires IDSEL.
// [R5] Claimed configs get DEVSEL; others ignored.
// [R6] IO cycles claimed only on BAR hit.
// [R7] Function regions byte only; local wider.
// [R8] IO byte regions check AD[1:0] against BE.
// [R9] Memory decoded like IO with memory BARs.
// [R10] Memory byte regions use one dword each.
// [R11] Memory byte lane must match lane select.
// [R12] All other commands are ignored.
// [R13] Every claim ends disconnect with data. Retried claims end with STOP and no TRDY.
// [R14] Retry while EEPROM load runs.
// [R15] DEVSEL two clocks after FRAME low.
// [R16] Fast back-to-back frames accepted.
// [R17] Any byte enables for config-type regions.
// [R18] Disabled lanes left unchanged on write.
// [R19] Parity generated and checked always. Address parity is checked only with serr_en_i set.
// [R20] Address parity error raises SERR, completes.
// [R21] No prefetch or buffering of reads.
// [R22] Local registers written by driver or EEPROM.
// [R23] Unimplemented configs discard write, read zero.
// [R24] One internal strobe per claimed data phase.
`include "cbpt_defs.svh"

module cbpt_target #(
  parameter int IO_BAR_BITS  = 5,
  parameter int MEM_BAR_BITS = 12
) (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  input  wire logic               eeprom_busy_i,
  input  wire logic               eeprom_pci_mode_i,
  input  wire logic [1:0]         byte_lane_select_i,
  input  wire logic [31:0]        bar_uart_io_i,
  input  wire logic [31:0]        bar_uart_mem_i,
  input  wire logic [31:0]        bar_lcl_io_i,
  input  wire logic [31:0]        bar_lcl_mem_i,
  input  wire logic [31:0]        bar_stat_mem_i,
  input  wire logic               io_en_i,
  input  wire logic               mem_en_i,
  input  wire logic               serr_en_i,
  input  wire logic [31:0]        rdata_i,
  input  wire logic [31:0]        ad_i,
  input  wire logic [3:0]         cbe_n_i,
  input  wire logic               par_i,
  input  wire logic               frame_n_i,
  input  wire logic               irdy_n_i,
  input  wire logic               idsel_i,
  output logic [31:0]             ad_o,
  output logic                    ad_oe_o,
  output logic                    par_o,
  output logic                    par_oe_o,
  output logic                    devsel_n_o,
  output logic                    trdy_n_o,
  output logic                    stop_n_o,
  output logic                    ctl_oe_o,
  output logic                    perr_n_o,
  output logic                    perr_oe_o,
  output logic                    serr_n_o,
  output logic                    serr_oe_o,
  output logic                    pci_mode_o,
  output cbpt_pkg::cbpt_req_type  req_o
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Two flops on every bus and EEPROM pin before any logic looks at it.
  logic [31:0] ad_s1_reg, ad_reg;
  logic [3:0]  cbe_s1_reg, cbe_reg;
  logic [4:0]  ctl_s1_reg, ctl_reg;
  logic [1:0]  ee_s1_reg, ee_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ad_s1_reg  <= 32'h0000_0000;
      ad_reg     <= 32'h0000_0000;
      cbe_s1_reg <= 4'hf;
      cbe_reg    <= 4'hf;
      ctl_s1_reg <= 5'h07;
      ctl_reg    <= 5'h07;
      ee_s1_reg  <= 2'h1;
      ee_reg     <= 2'h1;
    end else begin
      ad_s1_reg  <= ad_i;
      ad_reg     <= ad_s1_reg;
      cbe_s1_reg <= cbe_n_i;
      cbe_reg    <= cbe_s1_reg;
      ctl_s1_reg <= {idsel_i, par_i, irdy_n_i, frame_n_i, 1'b1};
      ctl_reg    <= ctl_s1_reg;
      ee_s1_reg  <= {eeprom_pci_mode_i, eeprom_busy_i};
      ee_reg     <= ee_s1_reg;
    end
  end

  logic frame_n, irdy_n, par_in, idsel;
  assign frame_n = ctl_reg[1];
  assign irdy_n  = ctl_reg[2];
  assign par_in  = ctl_reg[3];
  assign idsel   = ctl_reg[4];

  // --------------------------------------------------------------------
  // Mode selection
  // --------------------------------------------------------------------
  // Cardbus after reset; the EEPROM can switch to PCI only while it is
  // still loading, which is before any configuration access is served.
  logic pci_mode_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pci_mode_reg <= 1'b0;                        // [R1]
    end else if (ee_reg[0]) begin
      pci_mode_reg <= ee_reg[1];                   // [R1]
    end
  end

  // --------------------------------------------------------------------
  // Decode functions
  // --------------------------------------------------------------------
  // Base compare used for all BARs.
  function automatic logic bar_hit(input logic [31:0] bar,
                                   input logic [31:0] adr,
                                   input int          bits);
    logic [31:0] msk;
    msk = 32'hffff_ffff << bits;
    bar_hit = ((bar & msk) == (adr & msk));
  endfunction : bar_hit

  // Byte lane one-hot from a two-bit lane number, active low enables.
  function automatic logic [3:0] lane_be(input logic [1:0] lane);
    lane_be = ~(4'h1 << lane);
  endfunction : lane_be

  // --------------------------------------------------------------------
  // Transaction state machine
  // --------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_DECODE, ST_DATA, ST_TURN} cbpt_st_type;
  cbpt_st_type st_reg;
  logic        claim, frame_d_reg, retry_reg, sel_ok_reg;
  logic [31:0] adr_reg;
  logic [3:0]  cmd_reg;
  cbpt_pkg::cbpt_region_type rg_reg, rg_next;
  logic        addr_phase;
  logic        hit_next, cfg_cmd, io_cmd, mem_cmd;

  // Address phase: FRAME# newly low; also after a turnaround-free end.
  assign addr_phase = !frame_n && (frame_d_reg || st_reg == ST_TURN); // [R16]
  assign cfg_cmd = (cbe_reg == `CBPT_CMD_CFG_RD) ||
                   (cbe_reg == `CBPT_CMD_CFG_WR);
  assign io_cmd  = io_en_i && ((cbe_reg == `CBPT_CMD_IO_RD) ||
                   (cbe_reg == `CBPT_CMD_IO_WR));
  assign mem_cmd = mem_en_i && ((cbe_reg == `CBPT_CMD_MEM_RD) ||
                   (cbe_reg == `CBPT_CMD_MEM_WR));

  // Region decode; unlisted commands never hit.
  always_comb begin
    hit_next = 1'b0;
    rg_next  = cbpt_pkg::CBPT_RG_CFG;
    if (cfg_cmd && ad_reg[1:0] == 2'b00 && ad_reg[10:8] == 3'h0 &&
        (!pci_mode_reg || idsel)) begin             // [R3] [R4] [R5]
      hit_next = 1'b1;
    end else if (io_cmd && bar_hit(bar_uart_io_i, ad_reg, 3)) begin
      hit_next = 1'b1;                             // [R6]
      rg_next  = cbpt_pkg::CBPT_RG_UART_IO;
    end else if (io_cmd && bar_hit(bar_lcl_io_i, ad_reg, IO_BAR_BITS)) begin
      hit_next = 1'b1;                             // [R6]
      rg_next  = cbpt_pkg::CBPT_RG_LCL_IO;
    end else if (mem_cmd && bar_hit(bar_uart_mem_i, ad_reg, 5)) begin
      hit_next = 1'b1;                             // [R9]
      rg_next  = cbpt_pkg::CBPT_RG_UART_MEM;
    end else if (mem_cmd &&
                 bar_hit(bar_lcl_mem_i, ad_reg, MEM_BAR_BITS)) begin
      hit_next = 1'b1;                             // [R9]
      rg_next  = cbpt_pkg::CBPT_RG_LCL_MEM;
    end else if (mem_cmd &&
                 bar_hit(bar_stat_mem_i, ad_reg, MEM_BAR_BITS)) begin
      hit_next = 1'b1;                             // [R9]
      rg_next  = cbpt_pkg::CBPT_RG_STAT;
    end
  end                                              // [R12]

  assign claim = addr_phase && hit_next;

  // Sequence: decode clock, then DEVSEL with STOP, plus TRDY unless retrying.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg      <= ST_IDLE;
      frame_d_reg <= 1'b1;
      adr_reg     <= 32'h0000_0000;
      cmd_reg     <= 4'h0;
      rg_reg      <= cbpt_pkg::CBPT_RG_CFG;
      retry_reg   <= 1'b0;
    end else begin
      frame_d_reg <= frame_n;
      case (st_reg)
        ST_IDLE, ST_TURN: begin
          if (claim) begin
            st_reg    <= ST_DECODE;
            adr_reg   <= ad_reg;
            cmd_reg   <= cbe_reg;
            rg_reg    <= rg_next;
            retry_reg <= ee_reg[0];                // [R14]
          end else begin
            st_reg <= ST_IDLE;
          end
        end
        ST_DECODE: begin
          st_reg <= ST_DATA;                       // [R15]
        end
        ST_DATA: begin
          if (!irdy_n || retry_reg) begin
            st_reg <= ST_TURN;                     // [R13]
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Byte lane qualification and internal strobe
  // --------------------------------------------------------------------
  logic is_wr, lane_ok, cfg_impl;
  assign is_wr = cmd_reg[0];
  assign cfg_impl = (adr_reg[7:2] <= `CBPT_CFG_IMPL_TOP);
  always_comb begin
    lane_ok = 1'b1;                                // [R17] [R7]
    if (rg_reg == cbpt_pkg::CBPT_RG_UART_IO) begin
      lane_ok = (cbe_reg == lane_be(adr_reg[1:0])); // [R8]
    end else if (rg_reg == cbpt_pkg::CBPT_RG_UART_MEM) begin
      lane_ok = (cbe_reg == lane_be(byte_lane_select_i)); // [R11]
    end else if (rg_reg == cbpt_pkg::CBPT_RG_CFG) begin
      lane_ok = cfg_impl;                          // [R23]
    end
  end

  // Strobe only in the completing data clock, never ahead of it.
  logic xfer;
  assign xfer = (st_reg == ST_DATA) && !irdy_n && !retry_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_o <= '0;
    end else begin
      req_o.rd     <= xfer && !is_wr && lane_ok;  // [R24] [R21]
      req_o.wr     <= xfer && is_wr && lane_ok;   // [R24] [R22]
      req_o.region <= rg_reg;
      // Byte regions in memory take one dword per register.
      req_o.addr   <= (rg_reg == cbpt_pkg::CBPT_RG_UART_MEM) ?
                      {3'h0, adr_reg[6:2]} : adr_reg[7:0]; // [R10]
      req_o.be     <= ~cbe_reg;                    // [R18]
      req_o.wdata  <= ad_reg;
    end
  end

  // --------------------------------------------------------------------
  // Bus outputs and parity
  // --------------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = rdata_i;
    if (rg_reg == cbpt_pkg::CBPT_RG_CFG) begin
      if (!cfg_impl) begin
        rd_val = 32'h0000_0000;                    // [R23]
      end else if (adr_reg[7:2] == `CBPT_CIS_PTR_IDX) begin
        rd_val = pci_mode_reg ? 32'h0000_0000 : `CBPT_CIS_PTR_VAL; // [R2]
      end
    end
  end

  logic drive_rd;
  assign drive_rd = (st_reg == ST_DATA) && !is_wr;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      devsel_n_o <= 1'b1;
      trdy_n_o   <= 1'b1;
      stop_n_o   <= 1'b1;
      ctl_oe_o   <= 1'b0;
      ad_o       <= 32'h0000_0000;
      ad_oe_o    <= 1'b0;
      pci_mode_o <= 1'b0;
    end else begin
      pci_mode_o <= pci_mode_reg;
      devsel_n_o <= !(st_reg == ST_DECODE ||
                      (st_reg == ST_DATA && irdy_n && !retry_reg)); // [R15]
      trdy_n_o   <= !(st_reg == ST_DECODE && !retry_reg);  // [R13]
      stop_n_o   <= !(st_reg == ST_DECODE ||
                      (st_reg == ST_DATA && irdy_n));      // [R13] [R14]
      ctl_oe_o   <= (st_reg == ST_DECODE) || (st_reg == ST_DATA);
      ad_o       <= rd_val;
      ad_oe_o    <= (st_reg == ST_DECODE) && !is_wr;
    end
  end

  // Parity on read data trails the data by one clock.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      par_o    <= 1'b0;
      par_oe_o <= 1'b0;
    end else begin
      par_o    <= ^{ad_o, cbe_reg};                 // [R19]
      par_oe_o <= ad_oe_o;
    end
  end

  // Address parity arrives one clock after the address phase.
  logic addr_chk_reg, data_chk_reg;
  logic [35:0] chk_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_chk_reg <= 1'b0;
      data_chk_reg <= 1'b0;
      chk_reg      <= 36'h0_0000_0000;
      serr_n_o     <= 1'b1;
      serr_oe_o    <= 1'b0;
      perr_n_o     <= 1'b1;
      perr_oe_o    <= 1'b0;
    end else begin
      addr_chk_reg <= addr_phase;
      data_chk_reg <= xfer && is_wr;
      chk_reg      <= {ad_reg, cbe_reg};
      serr_n_o     <= !(addr_chk_reg && serr_en_i &&
                        ((^chk_reg) != par_in));   // [R20] [R19]
      serr_oe_o    <= addr_chk_reg && serr_en_i &&
                      ((^chk_reg) != par_in);
      perr_n_o     <= !(data_chk_reg && ((^chk_reg) != par_in)); // [R19]
      perr_oe_o    <= data_chk_reg;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_devsel_two_clk: assert property (claim |-> ##2 !devsel_n_o) // [R15]
    else $error("DEVSEL not two clocks after claim");
  a_stop_with_trdy: assert property (!trdy_n_o |-> !stop_n_o) // [R13]
    else $error("TRDY without STOP");
  a_retry_no_trdy: assert property (claim && ee_reg[0] |->
                                    ##2 trdy_n_o && !stop_n_o) // [R14]
    else $error("Retry not signalled during EEPROM load");
  a_no_claim_miss: assert property (addr_phase && !hit_next |->
                                    ##2 devsel_n_o[*2]) // [R12]
    else $error("Unclaimed cycle answered");
  a_pci_idsel: assert property (addr_phase && cfg_cmd && pci_mode_reg &&
                                !idsel |-> !claim) // [R4]
    else $error("PCI config claimed without IDSEL");
  a_one_strobe: assert property (req_o.rd || req_o.wr |=>
                                 !(req_o.rd || req_o.wr)) // [R24]
    else $error("Double internal strobe");
  a_lane_gate: assert property (xfer && rg_reg ==
                                cbpt_pkg::CBPT_RG_UART_MEM &&
                                cbe_reg != lane_be(byte_lane_select_i)
                                |=> !req_o.wr && !req_o.rd) // [R11]
    else $error("UART touched on wrong lane");
  a_mode_reset: assert property ($rose(rstn_i) |-> !pci_mode_reg) // [R1]
    else $error("Not cardbus after reset");
  a_cfg_zero: assert property (drive_rd && !trdy_n_o &&
                               rg_reg == cbpt_pkg::CBPT_RG_CFG && !cfg_impl
                               |-> ad_o == 32'h0000_0000) // [R23]
    else $error("Unimplemented config read not zero");

  c_cfg_access: cover property (claim && cfg_cmd);
  c_io_access:  cover property (claim && io_cmd);
  c_retry:      cover property (claim && ee_reg[0]);
  c_back2back:  cover property (st_reg == ST_TURN && claim);

endmodule : cbpt_target

// *** bench/cbpt_master.sv ***
// Bus master model that runs single data phase frames into the target.
module cbpt_master (
  input  wire logic        clk_i,
  input  wire logic [31:0] ad_bus_i,
  input  wire logic        devsel_n_i,
  input  wire logic        trdy_n_i,
  input  wire logic        stop_n_i,
  output logic      [31:0] ad_o,
  output logic      [3:0]  cbe_n_o,
  output logic             par_o,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             idsel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic par_flip;
  // ------------------------------------------------------------------
  // Bus drive
  // ------------------------------------------------------------------
  // Idle levels at time zero.
  initial begin
    ad_o = 32'h5a5a_a5a5;
    cbe_n_o = 4'hf;
    frame_n_o = 1'b1;
    irdy_n_o = 1'b1;
    idsel_o = 1'b0;
    par_flip = 1'b0;
  end
  // Parity lags AD by one clock; a flip corrupts the address phase.
  always @(negedge clk_i) par_o <= ^{ad_o, cbe_n_o} ^ par_flip;
  // One frame; status 0 ignored, 1 disconnect with data, 2 retry.
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
                      input logic [3:0] be_n, input logic [31:0] wd,
                      input logic idsel, input logic bad, input logic b2b,
                      output logic [1:0] st, output logic [31:0] rd,
                      output int lat);
    int n;
    @(negedge clk_i);
    frame_n_o <= 1'b0;
    irdy_n_o <= 1'b1;
    ad_o <= addr;
    cbe_n_o <= cmd;
    idsel_o <= idsel;
    par_flip <= bad;
    @(negedge clk_i);
    frame_n_o <= 1'b1;
    irdy_n_o <= 1'b0;
    cbe_n_o <= be_n;
    par_flip <= 1'b0;
    ad_o <= cmd[0] ? wd : ~addr;
    lat = 0;
    st = 2'h0;
    rd = 32'h0;
    // Everything is held until the edge that samples STOP# low.
    for (n = 0; n < 12; n++) begin
      @(posedge clk_i);
      if (devsel_n_i === 1'b0 && lat == 0) lat = n + 1;
      if (stop_n_i === 1'b0) begin
        st = (trdy_n_i === 1'b0) ? 2'h1 : 2'h2;
        rd = ad_bus_i;
        break;
      end
    end
    // Back to back frames skip the idle cycle entirely.
    if (!b2b) begin
      @(negedge clk_i);
      irdy_n_o <= 1'b1;
      ad_o <= ~ad_o;
      cbe_n_o <= 4'hf;
      idsel_o <= 1'b0;
    end
  endtask : xfer
endmodule : cbpt_master

// *** bench/cbpt_target_tb.sv ***
// Self-checking testbench of the cardbus/PCI target decoder.
`include "cbpt_defs.svh"
module cbpt_target_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rstn_i, busy, pmode, mem_en;
  logic [1:0] sel;
  logic [31:0] b_uio, b_umem, b_lio, b_lmem, b_stat, rdata_v, m_ad, ad_bus;
  logic [31:0] ad_o, seed, last_rd;
  logic [3:0] m_cbe;
  logic m_par, m_frame, m_irdy, m_idsel, bad_par, b2b;
  logic ad_oe_o, par_o, par_oe_o, devsel_n_o, trdy_n_o, stop_n_o, ctl_oe_o;
  logic perr_n_o, perr_oe_o, serr_n_o, serr_oe_o, pci_mode_o;
  cbpt_pkg::cbpt_req_type req_o;
  cbpt_pkg::cbpt_req_type exp_q[$];
  int num_errors, n_tests, n_serr, n_perr, i;
  // ------------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------------
  // Shared lines carry whoever has the output enable.
  assign ad_bus = ad_oe_o ? ad_o : m_ad;
  cbpt_target uut (.clk_i, .rstn_i, .eeprom_busy_i(busy),
    .eeprom_pci_mode_i(pmode), .byte_lane_select_i(sel),
    .bar_uart_io_i(b_uio), .bar_uart_mem_i(b_umem), .bar_lcl_io_i(b_lio),
    .bar_lcl_mem_i(b_lmem), .bar_stat_mem_i(b_stat), .io_en_i(1'b1),
    .mem_en_i(mem_en), .serr_en_i(1'b1), .rdata_i(rdata_v), .ad_i(ad_bus),
    .cbe_n_i(m_cbe), .par_i(par_oe_o ? par_o : m_par), .frame_n_i(m_frame),
    .irdy_n_i(m_irdy), .idsel_i(m_idsel), .ad_o, .ad_oe_o, .par_o,
    .par_oe_o, .devsel_n_o, .trdy_n_o, .stop_n_o, .ctl_oe_o, .perr_n_o,
    .perr_oe_o, .serr_n_o, .serr_oe_o, .pci_mode_o, .req_o);
  cbpt_master m (.clk_i, .ad_bus_i(ad_bus), .devsel_n_i(devsel_n_o),
    .trdy_n_i(trdy_n_o), .stop_n_i(stop_n_o), .ad_o(m_ad), .cbe_n_o(m_cbe),
    .par_o(m_par), .frame_n_o(m_frame), .irdy_n_o(m_irdy),
    .idsel_o(m_idsel));
  // Free running bus clock of 100 ns.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check_val(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  // Write data only matters in enabled lanes of a write.
  task automatic check_req(cbpt_pkg::cbpt_req_type e,
                           cbpt_pkg::cbpt_req_type g);
    logic [31:0] mk;
    mk = e.wr ? {{8{e.be[3]}}, {8{e.be[2]}}, {8{e.be[1]}}, {8{e.be[0]}}} : 0;
    g.wdata = g.wdata & mk;
    e.wdata = e.wdata & mk;
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error req expected %h seen %h", e, g);
    end
  endtask : check_req
  task automatic summarize();
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Notes the expected strobe, runs the frame, checks its ending.
  task automatic op(input logic [3:0] cmd, input logic [31:0] a,
                    input logic [3:0] be_n, input logic ids,
                    input logic [1:0] est, input logic strobe,
                    input cbpt_pkg::cbpt_region_type rg);
    logic [31:0] wd;
    logic [1:0] st;
    int lat;
    cbpt_pkg::cbpt_req_type e;
    wd = rnd();
    e = '0;
    e.rd = ~cmd[0];
    e.wr = cmd[0];
    e.region = rg;
    e.be = ~be_n;
    // Byte registers in memory space sit one per dword.
    e.addr = (rg == cbpt_pkg::CBPT_RG_UART_MEM) ? {3'h0, a[6:2]}
                                               : a[7:0];
    e.wdata = cmd[0] ? wd : 32'h0;
    if (strobe) exp_q.push_back(e);
    m.xfer(cmd, a, be_n, wd, ids, bad_par, b2b, st, last_rd, lat);
    check_val("status", {30'h0, est}, {30'h0, st});
    check_val("control enable", {31'h0, est != 2'h0},
              {31'h0, ctl_oe_o});
    if (est != 2'h0) check_val("devsel delay", 32'h4, lat);
  endtask : op
  // Each strobe takes the oldest note; config strobes are not noted.
  always @(posedge clk_i) begin
    if (serr_n_o === 1'b0 && serr_oe_o === 1'b1) n_serr++;
    if (perr_n_o === 1'b0 && perr_oe_o === 1'b1) n_perr++;
    if ((req_o.rd === 1'b1 || req_o.wr === 1'b1)
        && req_o.region !== cbpt_pkg::CBPT_RG_CFG) begin
      if (exp_q.size() == 0) check_val("spare strobe", 32'h0, 32'h1);
      else check_req(exp_q.pop_front(), req_o);
    end
  end
  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (8000) @(posedge clk_i);
    num_errors++;
    $display("Error watchdog expired");
    summarize();
  end
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {num_errors, n_tests, n_serr, n_perr} = '0;
    seed = 32'ha202;
    {rstn_i, busy, pmode, mem_en, sel, bad_par, b2b} = 8'b0101_0000;
    b_uio = (rnd() & 32'hf000) | 32'h100;
    b_lio = b_uio + 32'h100;
    b_umem = (rnd() & 32'hff00_0000) | 32'h1000;
    b_lmem = b_umem + 32'h1000;
    b_stat = b_umem + 32'h2000;
    rdata_v = rnd();
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    op(`CBPT_CMD_MEM_WR, b_lmem, 4'h0, 0, 2, 0,
       cbpt_pkg::CBPT_RG_LCL_MEM);
    busy = 1'b0;
    repeat (6) @(negedge clk_i);
    check_val("cardbus mode", 32'h0, {31'h0, pci_mode_o});
    op(`CBPT_CMD_CFG_RD, 32'h28, 4'h0, 0, 1, 0, cbpt_pkg::CBPT_RG_CFG);
    check_val("cis pointer", `CBPT_CIS_PTR_VAL, last_rd);
    op(`CBPT_CMD_CFG_RD, 32'h128, 4'h0, 0, 0, 0, cbpt_pkg::CBPT_RG_CFG);
    op(`CBPT_CMD_CFG_RD, 32'h29, 4'h0, 0, 0, 0, cbpt_pkg::CBPT_RG_CFG);
    op(`CBPT_CMD_CFG_WR, 32'h80, 4'ha, 0, 1, 0, cbpt_pkg::CBPT_RG_CFG);
    op(`CBPT_CMD_CFG_RD, 32'h80, 4'h0, 0, 1, 0, cbpt_pkg::CBPT_RG_CFG);
    check_val("unimplemented", 32'h0, last_rd);
    for (i = 0; i < 16; i++)
      if (!(i inside {2, 3, 6, 7, 10, 11}))
        op(4'(i), b_umem, 4'h0, 1, 0, 0, cbpt_pkg::CBPT_RG_UART_MEM);
    for (i = 0; i < 4; i++) begin
      op(`CBPT_CMD_IO_WR, b_uio + i, ~(4'h1 << i), 0, 1, 1,
         cbpt_pkg::CBPT_RG_UART_IO);
      op(`CBPT_CMD_IO_RD, b_uio + i, ~(4'h1 << (i ^ 1)), 0, 1, 0,
         cbpt_pkg::CBPT_RG_UART_IO);
      sel = 2'(i);
      op(`CBPT_CMD_MEM_WR, b_umem + (rnd() & 32'h1c), ~(4'h1 << i), 0, 1, 1,
         cbpt_pkg::CBPT_RG_UART_MEM);
      op(`CBPT_CMD_MEM_RD, b_umem + 4, ~(4'h1 << ((i + 1) % 4)), 0, 1, 0,
         cbpt_pkg::CBPT_RG_UART_MEM);
    end
    op(`CBPT_CMD_IO_WR, b_uio + 32'h400, 4'he, 0, 0, 0,
       cbpt_pkg::CBPT_RG_UART_IO);
    op(`CBPT_CMD_IO_WR, b_lio, 4'h0, 0, 1, 1, cbpt_pkg::CBPT_RG_LCL_IO);
    op(`CBPT_CMD_MEM_WR, b_stat, 4'h6, 0, 1, 1, cbpt_pkg::CBPT_RG_STAT);
    op(`CBPT_CMD_IO_RD, b_lio + 4, 4'h0, 0, 1, 1, cbpt_pkg::CBPT_RG_LCL_IO);
    check_val("local read", rdata_v, last_rd);
    b2b = 1'b1;
    op(`CBPT_CMD_MEM_WR, b_lmem, 4'hc, 0, 1, 1,
       cbpt_pkg::CBPT_RG_LCL_MEM);
    op(`CBPT_CMD_MEM_WR, b_umem + 8, 4'h7, 0, 1, 1,
       cbpt_pkg::CBPT_RG_UART_MEM);
    {b2b, bad_par} = 2'b01;
    op(`CBPT_CMD_MEM_WR, b_lmem + 4, 4'h0, 0, 1, 1,
       cbpt_pkg::CBPT_RG_LCL_MEM);
    {bad_par, mem_en} = 2'b00;
    op(`CBPT_CMD_MEM_WR, b_lmem, 4'h0, 0, 0, 0,
       cbpt_pkg::CBPT_RG_LCL_MEM);
    {busy, pmode, mem_en} = 3'b111;
    repeat (6) @(negedge clk_i);
    busy = 1'b0;
    repeat (6) @(negedge clk_i);
    check_val("pci mode", 32'h1, {31'h0, pci_mode_o});
    op(`CBPT_CMD_CFG_RD, 32'h28, 4'h0, 0, 0, 0, cbpt_pkg::CBPT_RG_CFG);
    op(`CBPT_CMD_CFG_RD, 32'h28, 4'h0, 1, 1, 0, cbpt_pkg::CBPT_RG_CFG);
    check_val("pci cis pointer", 32'h0, last_rd);
    repeat (10) @(negedge clk_i);
    check_val("pending notes", 32'h0, exp_q.size());
    check_val("serr pulses", 32'h1, n_serr);
    check_val("perr pulses", 32'h0, n_perr);
    summarize();
  end
endmodule : cbpt_target_tb
